// file: common/counter_latch_pkg.sv
// Shared constants, field layouts and carriers for the counter latch/sync/compare block
package counter_latch_pkg;

  // Register byte addresses on the Avalon-MM slave
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CONFIG = 8'h04;
  localparam logic [7:0] ADDR_LOAD = 8'h08;
  localparam logic [7:0] ADDR_CMP_A = 8'h0C;
  localparam logic [7:0] ADDR_CMP_B = 8'h10;
  localparam logic [7:0] ADDR_DIRECT = 8'h14;
  localparam logic [7:0] ADDR_FEEDBACK = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1C;
  localparam logic [7:0] ADDR_LIVE = 8'h20;

  typedef enum logic [1:0] {
    IN_PLAIN = 2'h0,
    IN_LATCH_RETRIG = 2'h1,
    IN_LATCH = 2'h2,
    IN_SYNC = 2'h3
  } inFunc_t;

  typedef enum logic [2:0] {
    OUT_PLAIN = 3'h0,
    OUT_GE = 3'h1,
    OUT_LE = 3'h2,
    OUT_PULSE = 3'h3,
    OUT_WINDOW = 3'h4
  } outFunc_t;

  typedef enum logic [1:0] {
    DIR_NONE = 2'h0,
    DIR_UP = 2'h1,
    DIR_DOWN = 2'h2
  } dirMode_t;

  // Control word, bit 0 is softwareGate
  typedef struct packed {
    logic busSync;
    logic virtualOutEnable;
    logic primaryOutEnable;
    logic forceVirtualOut;
    logic forcePrimaryOut;
    logic statusClearRequest;
    logic resyncEnable;
    logic softwareGate;
  } ctrl_t;

  // Configuration word, bits [1:0] are inputFunc
  typedef struct packed {
    logic [7:0] pulseLength;
    logic [7:0] hysteresis;
    outFunc_t funcB;
    outFunc_t funcA;
    dirMode_t mainDir;
    logic gateInterrupting;
    logic syncPeriodic;
    inFunc_t inputFunc;
  } cfg_t;

  localparam ctrl_t CTRL_RESET = 8'h00;
  localparam cfg_t CONFIG_RESET = 28'h0000000;
  localparam logic [31:0] COUNT_RESET = 32'h00000000;
  localparam logic [31:0] LATCH_RESET = 32'h00000000;
  localparam logic [31:0] LOAD_RESET = 32'h00000000;
  localparam logic [31:0] CMP_RESET = 32'h00000000;

  // Status word bit positions
  localparam int ST_EXT_LEVEL = 0;
  localparam int ST_RESYNC_DONE = 1;
  localparam int ST_PRIMARY_OUT = 2;
  localparam int ST_VIRTUAL_OUT = 3;
  localparam int ST_HIT_A = 4;
  localparam int ST_HIT_B = 5;
  localparam int ST_GATE = 6;
  localparam int ST_DIR_UP = 7;
  localparam int ST_PARAM_ERR = 8;

  // Pulse length step timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int PULSE_STEP_NS = 2000000;
  localparam int PULSE_STEP_CYCLES = PULSE_STEP_NS / CLK_PERIOD_NS;

endpackage

// file: design/counter_latch_sync_compare.sv
// Counter with input-edge latch, retrigger and resync, plus two compare outputs
`timescale 1ns/100ps
module counter_latch_sync_compare import counter_latch_pkg::*; #(
  parameter int STEP_CYCLES = PULSE_STEP_CYCLES
) (
  input wire logic core_clk, // Module clock, 100 MHz
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic [7:0] address, // Avalon byte address
  input wire logic read, // Avalon read request
  input wire logic write, // Avalon write request
  input wire logic [31:0] writedata, // Avalon write data
  output logic [31:0] readdata, // Avalon read data
  output logic waitrequest, // Avalon wait request
  input wire logic extInputPin, // External reference/latch input pin
  input wire logic countUpPulse, // One-cycle count up step
  input wire logic countDownPulse, // One-cycle count down step
  input wire logic busReadInstant, // One-cycle bus read instant strobe
  input wire logic busWriteInstant, // One-cycle bus write instant strobe
  output logic primarySwitchOut // Real switched output
);

  // ---------------- Registers ----------------
  ctrl_t ctrl_reg;
  cfg_t cfg_reg;
  logic signed [31:0] count_reg;
  logic signed [31:0] latch_reg;
  logic signed [31:0] loadValue_reg;
  logic signed [31:0] shownLatch_reg;
  logic signed [31:0] cmpVal_reg [2];
  logic waitReq_reg;
  logic [31:0] readData_reg;
  logic [1:0] extSync_reg;
  logic extLevel_reg;
  logic armed_reg;
  logic started_reg;
  logic syncUsed_reg;
  logic syncWindow_reg;
  logic resyncDone_reg;
  logic countMoved_reg;
  logic lastUp_reg;
  logic virtShown_reg;
  logic primaryOut_reg;
  logic [1:0] outOn_reg;
  logic [1:0] hitFlag_reg;
  logic [1:0] forceLatch_reg;
  logic [1:0] hystAct_reg;
  logic [7:0] pulseSteps_reg [2];
  logic [17:0] pulseCycles_reg [2];

  // ---------------- Bus decode ----------------
  wire wrTake = write & ~waitReq_reg;
  wire rdStart = read & waitReq_reg;
  wire selCtrl = (address == ADDR_CTRL);
  wire selConfig = (address == ADDR_CONFIG);
  wire selLoad = (address == ADDR_LOAD);
  wire selCmpA = (address == ADDR_CMP_A);
  wire selCmpB = (address == ADDR_CMP_B);
  wire selDirect = (address == ADDR_DIRECT);
  wire selFeedback = (address == ADDR_FEEDBACK);
  wire selStatus = (address == ADDR_STATUS);
  wire selLive = (address == ADDR_LIVE);
  wire wrCtrl = wrTake & selCtrl;
  ctrl_t ctrlWr;
  assign ctrlWr = ctrl_t'(writedata[7:0]);
  // Clear request is a command, never stored
  ctrl_t ctrlNext;
  assign ctrlNext = wrCtrl ? ctrl_t'({ctrlWr[7:3], 1'b0, ctrlWr[1:0]}) : ctrl_reg;
  wire clearPulse = wrCtrl & ctrlWr.statusClearRequest;
  wire gateRise = wrCtrl & ctrlWr.softwareGate & ~ctrl_reg.softwareGate;
  wire [1:0] forceNew = {ctrlNext.forceVirtualOut, ctrlNext.forcePrimaryOut};
  wire [1:0] forceOld = {ctrl_reg.forceVirtualOut, ctrl_reg.forcePrimaryOut};
  wire [1:0] forceRise = forceNew & ~forceOld;
  wire [1:0] forceFall = ~forceNew & forceOld;
  wire [1:0] outEnable = {ctrl_reg.virtualOutEnable, ctrl_reg.primaryOutEnable};

  // ---------------- Input synchroniser ----------------
  wire extRise = extSync_reg[1] & ~extLevel_reg;

  // ---------------- Counter core ----------------
  wire gateOpen = ctrl_reg.softwareGate;
  wire isRetrig = (cfg_reg.inputFunc == IN_LATCH_RETRIG);
  wire isLatch = (cfg_reg.inputFunc == IN_LATCH);
  wire isSync = (cfg_reg.inputFunc == IN_SYNC);
  wire directLoad = wrTake & selDirect;
  wire retrigEvt = isRetrig & armed_reg & extRise;
  wire latchEvt = retrigEvt | (isLatch & extRise);
  wire syncEvt = isSync & gateOpen & ctrl_reg.resyncEnable & extRise
    & (cfg_reg.syncPeriodic | ~syncUsed_reg);
  // Plain latch starts from load value; later opens load only when canceling
  wire latchGateLoad = isLatch & (~started_reg | ~cfg_reg.gateInterrupting);
  wire otherGateLoad = ~isLatch & ~isRetrig & ~cfg_reg.gateInterrupting;
  wire gateLoad = gateRise & (latchGateLoad | otherGateLoad);
  wire reload = retrigEvt | syncEvt | gateLoad;
  wire stepUp = gateOpen & countUpPulse & ~countDownPulse;
  wire stepDown = gateOpen & countDownPulse & ~countUpPulse;
  wire stepped = (stepUp | stepDown) & ~directLoad & ~reload;
  wire signed [31:0] countStepped = stepUp ? count_reg + 32'sh00000001 :
    stepDown ? count_reg - 32'sh00000001 : count_reg;
  wire signed [31:0] countNext = directLoad ? $signed(writedata) :
    reload ? loadValue_reg : countStepped;
  // Latch ignores direct load and the gate; retrigger mode first needs one gate opening to arm
  wire signed [31:0] latchNext = latchEvt ? count_reg : latch_reg;
  wire latchMode = isRetrig | isLatch;
  wire signed [31:0] feedbackCount = !latchMode ? count_reg :
    ctrl_reg.busSync ? shownLatch_reg : latch_reg;

  // Resync done flag; set wins over clear
  wire syncSetNow = ctrl_reg.busSync ?
    (busReadInstant & (syncWindow_reg | syncEvt)) : syncEvt;
  wire resyncDoneNext = syncSetNow | (resyncDone_reg & ~clearPulse);
  wire syncWindowNext = syncEvt | (syncWindow_reg & ~busReadInstant);

  // ---------------- Comparators ----------------
  wire paramError = (cfg_reg.funcA == OUT_WINDOW)
    & ((cfg_reg.hysteresis != 8'h00) | (cfg_reg.funcB != OUT_PLAIN));
  wire signed [31:0] hystSpan = $signed({24'h000000, cfg_reg.hysteresis});
  wire dirOk = (cfg_reg.mainDir == DIR_NONE) | ((cfg_reg.mainDir == DIR_UP) & lastUp_reg)
    | ((cfg_reg.mainDir == DIR_DOWN) & ~lastUp_reg);
  wire signed [31:0] v1 = cmpVal_reg[0];
  wire signed [31:0] v2 = cmpVal_reg[1];
  wire winInside = (count_reg >= v2) & (count_reg <= v1);
  wire winOutside = (count_reg < v1) | (count_reg > v2);
  wire winCond = (v2 < v1) ? winInside :
    (v2 == v1) ? (count_reg == v1) : winOutside;
  wire [1:0] outOnNext;
  wire [1:0] hitFlagNext;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_cmp
      wire outFunc_t func = (ch == 0) ? cfg_reg.funcA : cfg_reg.funcB;
      // Modular difference keeps the band correct across wrap
      wire signed [31:0] diff = count_reg - cmpVal_reg[ch];
      wire inBand = (diff >= -hystSpan) & (diff <= hystSpan);
      wire eq = (count_reg == cmpVal_reg[ch]);
      wire hit = countMoved_reg & eq & dirOk;
      wire isWindow = (func == OUT_WINDOW) & (ch == 0) & ~paramError;
      wire rawCond = (func == OUT_GE) ? (count_reg >= cmpVal_reg[ch]) :
        (func == OUT_LE) ? (count_reg <= cmpVal_reg[ch]) :
        (func == OUT_PULSE) ? eq :
        isWindow ? winCond : 1'b0;
      wire hystUsed = (cfg_reg.hysteresis != 8'h00) & ((func == OUT_GE)
        | (func == OUT_LE) | (func == OUT_PULSE));
      wire hystTrig = (func == OUT_PULSE) ? hit : rawCond;
      wire hystNext = hystUsed & inBand
        & (hystAct_reg[ch] | hystTrig);
      wire effCond = rawCond | hystAct_reg[ch];
      wire lenZero = (cfg_reg.pulseLength == 8'h00);
      wire pulseRun = (pulseSteps_reg[ch] != 8'h00);
      // Hysteresis blocks retrigger inside band; a forced set makes one pulse
      wire pulseStart = outEnable[ch] & (func == OUT_PULSE) & ~lenZero
        & ((hit & ~hystAct_reg[ch]) | forceRise[ch]);
      wire [7:0] stepsNext = pulseStart ? cfg_reg.pulseLength :
        (pulseRun & (pulseCycles_reg[ch] == 18'(STEP_CYCLES - 1))) ?
        pulseSteps_reg[ch] - 8'h01 : pulseSteps_reg[ch];
      wire [17:0] cyclesNext = (pulseStart | ~pulseRun
        | (pulseCycles_reg[ch] == 18'(STEP_CYCLES - 1))) ?
        18'h00000 : pulseCycles_reg[ch] + 18'h00001;
      wire forceable = (func != OUT_PULSE) & (func != OUT_WINDOW);
      wire forceLatchNext = (forceRise[ch] & forceable)
        | (forceLatch_reg[ch] & ~forceFall[ch] & forceable);
      // Full step count on, so the pin width equals the setting
      wire pulseOn = lenZero ? (eq | hystAct_reg[ch]) : pulseRun;
      wire funcOn = (func == OUT_PLAIN) ? forceLatch_reg[ch] :
        ((func == OUT_GE) | (func == OUT_LE)) ? (effCond | forceLatch_reg[ch]) :
        (func == OUT_PULSE) ? pulseOn : isWindow & rawCond;
      assign outOnNext[ch] = outEnable[ch] & funcOn;
      // Flag set wins over acknowledge, so ack only sticks once output is off
      assign hitFlagNext[ch] = outOn_reg[ch] | (forceRise[ch] & ~outEnable[ch])
        | (hitFlag_reg[ch] & ~clearPulse);

      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          hystAct_reg[ch] <= 1'b0;
          forceLatch_reg[ch] <= 1'b0;
          pulseSteps_reg[ch] <= 8'h00;
          pulseCycles_reg[ch] <= 18'h00000;
          outOn_reg[ch] <= 1'b0;
          hitFlag_reg[ch] <= 1'b0;
        end else begin
          hystAct_reg[ch] <= hystNext;
          forceLatch_reg[ch] <= forceLatchNext;
          pulseSteps_reg[ch] <= stepsNext;
          pulseCycles_reg[ch] <= cyclesNext;
          outOn_reg[ch] <= outOnNext[ch];
          hitFlag_reg[ch] <= hitFlagNext[ch];
        end
      end
    end
  endgenerate

  // ---------------- Output timing ----------------
  // With busSync set, primary waits for the bus write instant only in plain function; virtual output waits for the read instant in every function
  wire primaryHold = ctrl_reg.busSync & (cfg_reg.funcA == OUT_PLAIN) & ~busWriteInstant;
  wire primaryNext = primaryHold ? primaryOut_reg : outOn_reg[0];
  wire virtShownNext = (~ctrl_reg.busSync | busReadInstant) ?
    outOn_reg[1] : virtShown_reg;
  wire signed [31:0] shownLatchNext = busReadInstant ? latch_reg : shownLatch_reg;

  // ---------------- Read mux ----------------
  wire [31:0] statusWord = {23'h000000, paramError, lastUp_reg, gateOpen,
    hitFlag_reg[1], hitFlag_reg[0], virtShown_reg, primaryOut_reg,
    resyncDone_reg, extLevel_reg};
  wire [31:0] readMux = selCtrl ? {24'h000000, ctrl_reg} :
    selConfig ? {4'h0, cfg_reg} :
    selLoad ? loadValue_reg :
    selCmpA ? cmpVal_reg[0] :
    selCmpB ? cmpVal_reg[1] :
    selDirect ? count_reg :
    selFeedback ? feedbackCount :
    selStatus ? statusWord :
    selLive ? count_reg : 32'h00000000;

  assign readdata = readData_reg;
  assign waitrequest = waitReq_reg;
  assign primarySwitchOut = primaryOut_reg;

  // ---------------- Bus and configuration registers ----------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      waitReq_reg <= 1'b1;
      readData_reg <= 32'h00000000;
      ctrl_reg <= CTRL_RESET;
      cfg_reg <= CONFIG_RESET;
      loadValue_reg <= LOAD_RESET;
      cmpVal_reg[0] <= CMP_RESET;
      cmpVal_reg[1] <= CMP_RESET;
    end else begin
      waitReq_reg <= ~((read | write) & waitReq_reg);
      readData_reg <= rdStart ? readMux : readData_reg;
      ctrl_reg <= ctrlNext;
      cfg_reg <= (wrTake & selConfig) ? cfg_t'(writedata[27:0]) : cfg_reg;
      loadValue_reg <= (wrTake & selLoad) ? $signed(writedata) : loadValue_reg;
      cmpVal_reg[0] <= (wrTake & selCmpA) ? $signed(writedata) : cmpVal_reg[0];
      cmpVal_reg[1] <= (wrTake & selCmpB) ? $signed(writedata) : cmpVal_reg[1];
    end
  end

  // ---------------- Input, counter and latch ----------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      extSync_reg <= 2'h0;
      extLevel_reg <= 1'b0;
      count_reg <= COUNT_RESET;
      latch_reg <= LATCH_RESET;
      shownLatch_reg <= LATCH_RESET;
      countMoved_reg <= 1'b0;
      lastUp_reg <= 1'b1;
    end else begin
      extSync_reg <= {extSync_reg[0], extInputPin};
      extLevel_reg <= extSync_reg[1];
      count_reg <= countNext;
      latch_reg <= latchNext;
      shownLatch_reg <= shownLatchNext;
      countMoved_reg <= stepped;
      lastUp_reg <= stepUp ? 1'b1 : stepDown ? 1'b0 : lastUp_reg;
    end
  end

  // ---------------- Mode state and feedback flags ----------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      armed_reg <= 1'b0;
      started_reg <= 1'b0;
      syncUsed_reg <= 1'b0;
      syncWindow_reg <= 1'b0;
      resyncDone_reg <= 1'b0;
      virtShown_reg <= 1'b0;
      primaryOut_reg <= 1'b0;
    end else begin
      armed_reg <= isRetrig & (armed_reg | gateOpen);
      started_reg <= isLatch & (started_reg | gateRise);
      syncUsed_reg <= ctrl_reg.resyncEnable & (syncUsed_reg | syncEvt);
      syncWindow_reg <= syncWindowNext;
      resyncDone_reg <= resyncDoneNext;
      virtShown_reg <= virtShownNext;
      primaryOut_reg <= primaryNext;
    end
  end

endmodule

// file: tb/counter_latch_sync_compare_monitor.sv
// Checker for the register handshake and the switched output
`timescale 1ns/100ps
module counter_latch_sync_compare_monitor import counter_latch_pkg::*; #(
  parameter int STEP_CYCLES = PULSE_STEP_CYCLES
) (
  input wire logic core_clk, // Clock
  input wire logic rst_n, // Reset, active low
  input wire logic [7:0] address, // Byte address
  input wire logic read, // Read request
  input wire logic write, // Write request
  input wire logic [31:0] writedata, // Write data
  input wire logic [31:0] readdata, // Read data
  input wire logic waitrequest, // Wait request
  input wire logic primarySwitchOut // Real output
);
  ctrl_t ctrlShadow;
  cfg_t cfgShadow;
  int hiRun;
  wire logic wrDone = write && !waitrequest;
  wire logic rdDone = read && !waitrequest;
  wire logic unmapped = address[1:0] != 2'h0 || address > ADDR_LIVE;
  wire logic pulseOn = cfgShadow.funcA == OUT_PULSE && cfgShadow.pulseLength != 8'h00 &&
    ctrlShadow.primaryOutEnable && !ctrlShadow.forcePrimaryOut;
  wire logic plainOff = cfgShadow.funcA == OUT_PLAIN && !ctrlShadow.primaryOutEnable &&
    !ctrlShadow.busSync;
  // Shadows follow accepted writes so mode and readback can be judged
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrlShadow <= CTRL_RESET;
      cfgShadow <= CONFIG_RESET;
      hiRun <= 0;
    end else begin
      if (wrDone && address == ADDR_CTRL) ctrlShadow <= ctrl_t'(writedata[7:0]);
      if (wrDone && address == ADDR_CONFIG) cfgShadow <= cfg_t'(writedata[27:0]);
      hiRun <= primarySwitchOut ? hiRun + 1 : 0;
    end
  end
  default clocking mcb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  chk_wait_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("request not answered after one wait cycle");
  chk_wait_single: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low for more than one cycle");
  chk_rdata_hold: assert property (!(read && waitrequest) |=> $stable(readdata))
    else $error("readdata changed without a read");
  chk_unmapped_zero: assert property (rdDone && unmapped |-> readdata == 32'h0)
    else $error("unmapped read returned data");
  chk_ctrl_readback: assert property (rdDone && address == ADDR_CTRL |->
    readdata == ({24'h0, ctrlShadow} & 32'hFFFFFFFB)) else $error("control readback wrong");
  chk_out_disabled: assert property (plainOff [*3] |-> !primarySwitchOut)
    else $error("disabled plain output is on");
  chk_pulse_len: assert property ($fell(primarySwitchOut) && pulseOn |->
    hiRun == int'(cfgShadow.pulseLength) * STEP_CYCLES) else $error("pulse length wrong");
  chk_pulse_max: assert property (pulseOn && primarySwitchOut |->
    hiRun < int'(cfgShadow.pulseLength) * STEP_CYCLES) else $error("pulse too long");
  cover property ($fell(primarySwitchOut) && pulseOn);
  cover property (rdDone && unmapped);
  cover property ($rose(primarySwitchOut));
endmodule
bind counter_latch_sync_compare counter_latch_sync_compare_monitor #(.STEP_CYCLES(STEP_CYCLES))
  mon_u (.core_clk(core_clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
  .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
  .primarySwitchOut(primarySwitchOut));

// file: tb/ext_sensor_model.sv
// Reference sensor on the input pin and actuator on the switched output
`timescale 1ns/100ps
module ext_sensor_model (
  input wire logic core_clk, // Clock
  input wire logic primarySwitchOut, // Actuator drive
  output logic extInputPin // Sensor level
);
  int runLen = 0;
  int lastRun = 0;
  initial extInputPin = 1'b0;
  // Bounce-free edge, held past the two-stage synchroniser
  task automatic fire(input int holdCycles);
    @(posedge core_clk);
    extInputPin <= 1'b1;
    repeat (holdCycles) @(posedge core_clk);
    extInputPin <= 1'b0;
    repeat (holdCycles + 2) @(posedge core_clk);
  endtask
  // Actuator keeps the length of the last on-time
  always @(posedge core_clk) begin
    if (primarySwitchOut === 1'b1) runLen <= runLen + 1;
    else if (runLen != 0) begin
      lastRun <= runLen;
      runLen <= 0;
    end
  end
endmodule

// file: tb/counter_latch_sync_compare_tb_top.sv
// Self-checking bench for the counter latch, resync and compare block
`timescale 1ns/100ps
module counter_latch_sync_compare_tb_top import counter_latch_pkg::*;;
  localparam int STEP = 10;
  typedef struct packed {
    logic [31:0] v1;
    logic [31:0] v2;
    logic [31:0] cnt;
    logic on;
  } winRow_t;
  winRow_t rows[9] = '{'{32'hA, 32'h5, 32'h5, 1'b1}, '{32'hA, 32'h5, 32'hA, 1'b1},
    '{32'hA, 32'h5, 32'h4, 1'b0}, '{32'hA, 32'h5, 32'hB, 1'b0}, '{32'h7, 32'h7, 32'h7, 1'b1},
    '{32'h7, 32'h7, 32'h8, 1'b0}, '{32'hFFFFFFFD, 32'h2, 32'h2, 1'b0},
    '{32'hFFFFFFFD, 32'h2, 32'hFFFFFFFC, 1'b1}, '{32'hFFFFFFFD, 32'h2, 32'h3, 1'b1}};
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic extInputPin;
  logic countUpPulse = 1'b0;
  logic countDownPulse = 1'b0;
  logic busReadInstant = 1'b0;
  logic busWriteInstant = 1'b0;
  logic primarySwitchOut;
  logic [31:0] q;
  int n_fail = 0;
  int n_compared = 0;
  counter_latch_sync_compare #(.STEP_CYCLES(STEP)) dut_u (.core_clk(core_clk), .rst_n(rst_n),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .extInputPin(extInputPin),
    .countUpPulse(countUpPulse), .countDownPulse(countDownPulse),
    .busReadInstant(busReadInstant), .busWriteInstant(busWriteInstant),
    .primarySwitchOut(primarySwitchOut));
  ext_sensor_model sensor_u (.core_clk(core_clk), .primarySwitchOut(primarySwitchOut),
    .extInputPin(extInputPin));
  always #5 core_clk = ~core_clk;
  task automatic end_sim();
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic ck(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected word at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cb(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected bit at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Holds the request until waitrequest is seen low; bounded wait
  task automatic xfer(input logic [7:0] a, input logic wr, input logic [31:0] d);
    int i;
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    i = 0;
    do begin
      @(posedge core_clk);
      i++;
    end while (waitrequest !== 1'b0 && i < 50);
    if (waitrequest !== 1'b0) begin
      n_fail++;
      end_sim();
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask
  task automatic rk(input logic [7:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0);
    ck(q, exp);
  endtask
  task automatic sk(input int b, input logic exp);
    xfer(ADDR_STATUS, 1'b0, 32'h0);
    cb(q[b], exp);
  endtask
  task automatic pin(input logic exp);
    repeat (4) @(posedge core_clk);
    cb(primarySwitchOut, exp);
  endtask
  task automatic step(input logic up, input int n);
    repeat (n) begin
      countUpPulse <= up;
      countDownPulse <= !up;
      @(posedge core_clk);
      countUpPulse <= 1'b0;
      countDownPulse <= 1'b0;
      @(posedge core_clk);
    end
  endtask
  // One-cycle bus read and write instants
  task automatic strobe(input logic r, input logic w);
    busReadInstant <= r;
    busWriteInstant <= w;
    @(posedge core_clk);
    busReadInstant <= 1'b0;
    busWriteInstant <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic cfg(input inFunc_t f, input outFunc_t a, input logic [7:0] pl,
      input logic per, input dirMode_t d);
    cfg_t c;
    c = CONFIG_RESET;
    c.inputFunc = f;
    c.funcA = a;
    c.pulseLength = pl;
    c.syncPeriodic = per;
    c.mainDir = d;
    wr(ADDR_CONFIG, {4'h0, c});
  endtask
  initial begin
    repeat (8) @(posedge core_clk);
    cb(waitrequest, 1'b1);
    ck(readdata, 32'h0);
    cb(primarySwitchOut, 1'b0);
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    cfg(IN_PLAIN, OUT_WINDOW, 8'h0, 1'b0, DIR_NONE);
    foreach (rows[i]) begin
      wr(ADDR_CTRL, 32'h0);
      wr(ADDR_CMP_A, rows[i].v1);
      wr(ADDR_CMP_B, rows[i].v2);
      wr(ADDR_DIRECT, rows[i].cnt);
      wr(ADDR_CTRL, 32'h20);
      pin(rows[i].on);
    end
    rk(ADDR_CTRL, 32'h20);
    rk(8'h24, 32'h0);
    wr(ADDR_LIVE, 32'h77);
    rk(ADDR_LIVE, 32'h3);
    wr(ADDR_CTRL, 32'h0);
    cfg(IN_LATCH_RETRIG, OUT_PLAIN, 8'h0, 1'b0, DIR_NONE);
    wr(ADDR_LOAD, 32'h10);
    sensor_u.fire(4);
    rk(ADDR_FEEDBACK, 32'h0);
    rk(ADDR_LIVE, 32'h3);
    wr(ADDR_CTRL, 32'h1);
    wr(ADDR_DIRECT, 32'h100);
    rk(ADDR_FEEDBACK, 32'h0);
    step(1'b1, 3);
    sensor_u.fire(8);
    rk(ADDR_FEEDBACK, 32'h103);
    rk(ADDR_LIVE, 32'h10);
    wr(ADDR_CTRL, 32'h0);
    step(1'b1, 2);
    rk(ADDR_LIVE, 32'h10);
    wr(ADDR_DIRECT, 32'h30);
    sensor_u.fire(4);
    rk(ADDR_FEEDBACK, 32'h30);
    wr(ADDR_CTRL, 32'h1);
    step(1'b1, 1);
    rk(ADDR_LIVE, 32'h11);
    wr(ADDR_CTRL, 32'h0);
    cfg(IN_LATCH, OUT_PLAIN, 8'h0, 1'b0, DIR_NONE);
    wr(ADDR_LOAD, 32'h20);
    wr(ADDR_CTRL, 32'h1);
    step(1'b1, 2);
    sensor_u.fire(4);
    rk(ADDR_FEEDBACK, 32'h22);
    rk(ADDR_LIVE, 32'h22);
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_DIRECT, 32'h55);
    sensor_u.fire(8);
    rk(ADDR_FEEDBACK, 32'h55);
    wr(ADDR_CTRL, 32'h1);
    rk(ADDR_LIVE, 32'h20);
    // Interrupting gate: reopening keeps the count instead of the load value
    step(1'b1, 1);
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_CONFIG, 32'h0000000A);
    wr(ADDR_CTRL, 32'h1);
    rk(ADDR_LIVE, 32'h21);
    wr(ADDR_CTRL, 32'h0);
    cfg(IN_SYNC, OUT_PLAIN, 8'h0, 1'b0, DIR_NONE);
    wr(ADDR_LOAD, 32'h40);
    wr(ADDR_CTRL, 32'h1);
    wr(ADDR_DIRECT, 32'h5);
    sensor_u.fire(4);
    rk(ADDR_LIVE, 32'h5);
    wr(ADDR_CTRL, 32'h3);
    sensor_u.fire(4);
    rk(ADDR_LIVE, 32'h40);
    sk(ST_RESYNC_DONE, 1'b1);
    step(1'b1, 1);
    sensor_u.fire(4);
    rk(ADDR_LIVE, 32'h41);
    wr(ADDR_CTRL, 32'h7);
    sk(ST_RESYNC_DONE, 1'b0);
    wr(ADDR_CTRL, 32'h1);
    cfg(IN_SYNC, OUT_PLAIN, 8'h0, 1'b1, DIR_NONE);
    wr(ADDR_CTRL, 32'h3);
    repeat (2) begin
      step(1'b1, 1);
      sensor_u.fire(4);
      rk(ADDR_LIVE, 32'h40);
    end
    wr(ADDR_CTRL, 32'h4);
    cfg(IN_PLAIN, OUT_PLAIN, 8'h0, 1'b0, DIR_NONE);
    wr(ADDR_CTRL, 32'h8);
    sk(ST_HIT_A, 1'b1);
    cb(primarySwitchOut, 1'b0);
    wr(ADDR_CTRL, 32'h4);
    sk(ST_HIT_A, 1'b0);
    wr(ADDR_CTRL, 32'h28);
    pin(1'b1);
    sk(ST_PRIMARY_OUT, 1'b1);
    wr(ADDR_CTRL, 32'h2C);
    sk(ST_HIT_A, 1'b1);
    wr(ADDR_CTRL, 32'h20);
    cfg(IN_PLAIN, OUT_GE, 8'h0, 1'b0, DIR_NONE);
    wr(ADDR_CMP_A, 32'h5);
    // Gate opening reloads the counter, so the start value follows it
    wr(ADDR_CTRL, 32'h21);
    wr(ADDR_DIRECT, 32'h3);
    step(1'b1, 2);
    pin(1'b1);
    wr(ADDR_CTRL, 32'h25);
    sk(ST_HIT_A, 1'b1);
    step(1'b0, 3);
    pin(1'b0);
    wr(ADDR_CTRL, 32'h25);
    sk(ST_HIT_A, 1'b0);
    // Hysteresis of 3 holds the result until the count leaves the band
    wr(ADDR_CONFIG, 32'h00003040);
    step(1'b1, 3);
    step(1'b0, 1);
    pin(1'b1);
    step(1'b0, 3);
    pin(1'b0);
    cfg(IN_PLAIN, OUT_PULSE, 8'h2, 1'b0, DIR_UP);
    wr(ADDR_DIRECT, 32'h6);
    step(1'b0, 1);
    pin(1'b0);
    wr(ADDR_DIRECT, 32'h4);
    step(1'b1, 1);
    pin(1'b1);
    repeat (30) @(posedge core_clk);
    ck(32'(sensor_u.lastRun), 32'(2 * STEP));
    cfg(IN_PLAIN, OUT_PULSE, 8'h0, 1'b0, DIR_NONE);
    wr(ADDR_DIRECT, 32'h4);
    step(1'b1, 1);
    repeat (40) @(posedge core_clk);
    cb(primarySwitchOut, 1'b1);
    step(1'b1, 1);
    pin(1'b0);
    // Bus-synchronous: flag, feedback and outputs move on the instants
    cfg(IN_SYNC, OUT_PLAIN, 8'h0, 1'b1, DIR_NONE);
    wr(ADDR_CTRL, 32'h83);
    sensor_u.fire(4);
    rk(ADDR_LIVE, 32'h40);
    sk(ST_RESYNC_DONE, 1'b0);
    strobe(1'b1, 1'b0);
    sk(ST_RESYNC_DONE, 1'b1);
    cfg(IN_LATCH, OUT_PLAIN, 8'h0, 1'b0, DIR_NONE);
    step(1'b1, 2);
    sensor_u.fire(4);
    rk(ADDR_FEEDBACK, 32'h55);
    strobe(1'b1, 1'b0);
    rk(ADDR_FEEDBACK, 32'h42);
    cfg(IN_PLAIN, OUT_PLAIN, 8'h0, 1'b0, DIR_NONE);
    wr(ADDR_CTRL, 32'hF8);
    pin(1'b0);
    sk(ST_VIRTUAL_OUT, 1'b0);
    strobe(1'b1, 1'b1);
    pin(1'b1);
    sk(ST_VIRTUAL_OUT, 1'b1);
    sk(ST_HIT_B, 1'b1);
    // Reset in mid-run clears the output at once
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    cb(primarySwitchOut, 1'b0);
    cb(waitrequest, 1'b1);
    rst_n <= 1'b1;
    @(posedge core_clk);
    rk(ADDR_CTRL, 32'h0);
    end_sim();
  end
endmodule
